// ==== include/bsl_pkg.sv ====
package bsl_pkg;

    // ==========================================
    // register map (byte addresses, word aligned)
    // ==========================================
    localparam logic [7:0] BSL_ADDR_STRAP    = 8'h00;
    localparam logic [7:0] BSL_ADDR_OVERRIDE = 8'h04;
    localparam logic [7:0] BSL_ADDR_EFFECT   = 8'h08;
    localparam logic [7:0] BSL_ADDR_BOOT     = 8'h0c;

    // ==========================================
    // strap bit positions
    // ==========================================
    localparam int BSL_BIT_VOLT   = 0;
    localparam int BSL_BIT_BSEL   = 1;
    localparam int BSL_BIT_BQUAL  = 2;
    localparam int BSL_BIT_LOGTIM = 3;
    localparam int BSL_BIT_TIM2   = 4;
    localparam int BSL_NSTRAP     = 5;

    // pull direction during reset: 1 = pull-up
    localparam logic [4:0] BSL_PULL_UP   = 5'h1a;
    localparam logic [4:0] BSL_PULL_EN   = 5'h1f;

    // ==========================================
    // override register fields
    // ==========================================
    localparam int BSL_OVR_VOLT_EN  = 0;
    localparam int BSL_OVR_VOLT_VAL = 1;
    localparam int BSL_OVR_TIM_EN   = 2;
    localparam int BSL_OVR_TIM_LO   = 3;
    localparam logic [31:0] BSL_OVR_MASK = 32'h0000001f;

    // boot log is gated by its strap for this many cycles after reset release
    localparam int BSL_BOOT_CYCLES = 256;

    typedef enum logic [1:0] {
        BSL_BOOT_SPI      = 2'h1,
        BSL_BOOT_DOWNLOAD = 2'h2,
        BSL_BOOT_UNDEF    = 2'h3
    } bsl_boot_t;

    typedef struct packed {
        logic       volt_1v8;
        logic [1:0] sdio_timing;
    } bsl_cfg_t;

endpackage : bsl_pkg

// ==== sim/boot_strap_latch_bench.sv ====
module boot_strap_latch_bench
    import bsl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, tx = 0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [4:0]  want = 5'h00, drive = 5'h1f, s, pin, pull_en, pull_up;
    logic        ack, volt, mode, log_en, tx_o;
    logic [1:0]  tim, boot;
    logic [3:0]  sel = 4'hf;
    int          err_total = 0, n_tests = 0;
    bsl_top #(.BOOT_CYCLES(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .sdio_voltage_strap_i(pin[0]),
        .boot_select_strap_i(pin[1]), .boot_qualifier_strap_i(pin[2]),
        .log_and_timing_strap_i(pin[3]), .sdio_timing_strap_i(pin[4]),
        .strap_pull_en_o(pull_en), .strap_pull_up_o(pull_up), .strap_mode_o(mode),
        .volt_1v8_o(volt), .sdio_timing_o(tim), .boot_mode_o(boot),
        .boot_log_en_o(log_en), .boot_log_tx_i(tx), .boot_log_tx_o(tx_o));
    bsl_strap_board board (.clk_i(clk_i), .rst_i(rst_i), .pull_en_i(pull_en),
        .pull_up_i(pull_up), .want_i(want), .drive_i(drive), .pin_o(pin));
    initial
        forever #12.5 clk_i = ~clk_i;
    // ==========================================
    // tasks
    // ==========================================
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wrap_up;
        $display("tests=%0d errors=%0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        n = 0;
        do
            @(posedge clk_i);
        while (ack !== 1'b1 && ++n < 20);
        if (ack !== 1'b1)
        begin
            err_total++;
            wrap_up();
        end
        else
        begin
            q = rdat;
            {cyc, stb} <= 2'b00;
        end
    endtask : xfer
    // pins only hold the board level while reset is up
    task automatic boot_with(input logic [4:0] w, input logic [4:0] d);
        @(posedge clk_i);
        {rst_i, want, drive} <= {1'b1, w, d};
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask : boot_with
    // ==========================================
    // sequence
    // ==========================================
    initial
    begin
        for (int i = 0; i < 5; i++)
        begin
            s = (i < 4 ? {i[0], i[1], i[0], i[1], 1'b0} : 5'h1a) | 5'h01;
            boot_with(s & 5'h1e, i < 4 ? 5'h1f : 5'h00);
            chk(volt, 1'b1);
            chk(pull_up, 5'h1a);
            chk({mode, pull_en}, 6'h00);
            chk(boot, s[1] ? 2'h1 : s[2] ? 2'h3 : 2'h2);
            chk(tim, {s[3], s[4]});
            chk(tx_o, !s[3]);
            repeat (8) @(posedge clk_i);
            chk(tx_o, 1'b0);
            xfer(1'b0, BSL_ADDR_STRAP, 32'h0);
            chk(q, s);
        end
        xfer(1'b0, BSL_ADDR_BOOT, 32'h0);
        chk(q[2:0], 3'h5);
        xfer(1'b1, BSL_ADDR_OVERRIDE, 32'h0000000d);
        repeat (2) @(posedge clk_i);
        chk({volt, tim}, 3'h1);
        xfer(1'b0, BSL_ADDR_OVERRIDE, 32'h0);
        chk(q, 32'h0000000d);
        // no byte lane enabled: the override must keep its value
        sel <= 4'h0;
        xfer(1'b1, BSL_ADDR_OVERRIDE, 32'hffffffff);
        sel <= 4'hf;
        xfer(1'b0, BSL_ADDR_OVERRIDE, 32'h0);
        chk(q, 32'h0000000d);
        xfer(1'b0, BSL_ADDR_EFFECT, 32'h0);
        chk(q, 32'h00000001);
        xfer(1'b1, BSL_ADDR_STRAP, 32'h0);
        xfer(1'b0, BSL_ADDR_STRAP, 32'h0);
        chk(q, 32'h0000001b);
        xfer(1'b1, 8'h40, 32'hffffffff);
        xfer(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0);
        wrap_up();
    end
endmodule : boot_strap_latch_bench

// ==== sim/bsl_strap_board.sv ====
module bsl_strap_board
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // device pulls and board wishes
    input  wire logic [4:0] pull_en_i,
    input  wire logic [4:0] pull_up_i,
    input  wire logic [4:0] want_i,
    input  wire logic [4:0] drive_i,
    // strap pins
    output logic [4:0]      pin_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [4:0] busy_q = 5'h00;
    // after reset the pins carry unrelated traffic
    always_ff @(posedge clk_i)
        busy_q <= ~busy_q;
    // an undriven, unpulled pin shows no stable level
    always_comb
        for (int i = 0; i < 5; i++)
            pin_o[i] = !rst_i ? busy_q[i] : drive_i[i] ? want_i[i]
                : pull_en_i[i] ? pull_up_i[i] : ~busy_q[i];
endmodule : bsl_strap_board

// ==== sim/bsl_top_assertions.sv ====
module bsl_top_assertions
(
    input logic       clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o,
    input logic       boot_select_strap_i, boot_qualifier_strap_i,
    input logic       log_and_timing_strap_i, sdio_timing_strap_i,
    input logic [4:0] strap_pull_en_o,
    input logic       strap_mode_o, volt_1v8_o, boot_log_en_o,
    input logic [1:0] boot_mode_o,
    input logic       boot_log_tx_i, boot_log_tx_o
);
    logic [3:0] lat_q;
    // shadow of the straps the device must keep
    always_ff @(posedge clk_i)
        if (rst_i)
            lat_q <= {sdio_timing_strap_i, log_and_timing_strap_i,
                      boot_qualifier_strap_i, boot_select_strap_i};
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence settled_s; !rst_i && !$past(rst_i); endsequence
    sequence boot_open_s; $fell(rst_i) ##1 !boot_log_en_o; endsequence
    chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    chk_reset_pulls: assert property (disable iff (1'b0) strap_pull_en_o == (rst_i ? 5'h1f : 5'h00))
        else $error("pull enables wrong");
    chk_pins_released: assert property (disable iff (1'b0) strap_mode_o == rst_i)
        else $error("strap mode wrong");
    chk_volt_high: assert property ($fell(rst_i) |=> volt_1v8_o)
        else $error("memory supply not 1.8");
    chk_boot_decode: assert property (settled_s |-> boot_mode_o == (lat_q[0] ? 2'h1 : lat_q[1] ? 2'h3 : 2'h2))
        else $error("boot mode wrong");
    chk_log_flag: assert property (settled_s |-> boot_log_en_o == lat_q[2])
        else $error("log enable wrong");
    chk_log_pass: assert property (boot_log_en_o |-> boot_log_tx_o == boot_log_tx_i)
        else $error("log line blocked");
    chk_log_idle: assert property (boot_open_s |-> boot_log_tx_o)
        else $error("log line not silent");
endmodule : bsl_top_assertions
bind bsl_top bsl_top_assertions chk (.*);

// ==== src/bsl_decode.sv ====
module bsl_decode
    import bsl_pkg::*;
(
    // latched straps
    input  wire logic [4:0] strap_i,
    // override controls
    input  wire logic [4:0] ovr_i,
    // decoded settings
    output bsl_boot_t       boot_o,
    output logic            log_en_o,
    output bsl_cfg_t        cfg_o
);

    always_comb
    begin
        // qualifier is ignored once flash boot is chosen
        if (strap_i[BSL_BIT_BSEL])
        begin
            boot_o = BSL_BOOT_SPI;
        end
        else if (!strap_i[BSL_BIT_BQUAL])
        begin
            boot_o = BSL_BOOT_DOWNLOAD;
        end
        else
        begin
            boot_o = BSL_BOOT_UNDEF;
        end
        log_en_o = strap_i[BSL_BIT_LOGTIM];
        cfg_o.volt_1v8 = ovr_i[BSL_OVR_VOLT_EN] ? ovr_i[BSL_OVR_VOLT_VAL]
                                               : strap_i[BSL_BIT_VOLT];
        cfg_o.sdio_timing = ovr_i[BSL_OVR_TIM_EN] ? ovr_i[BSL_OVR_TIM_LO +: 2]
                          : {strap_i[BSL_BIT_LOGTIM], strap_i[BSL_BIT_TIM2]};
    end

endmodule : bsl_decode

// ==== src/bsl_top.sv ====
// Added by the designer: the Wishbone interface to the registers and the address map.
module bsl_top
    import bsl_pkg::*;
#(
    parameter int BOOT_CYCLES = BSL_BOOT_CYCLES
)
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // strap pins
    input  wire logic        sdio_voltage_strap_i,
    input  wire logic        boot_select_strap_i,
    input  wire logic        boot_qualifier_strap_i,
    input  wire logic        log_and_timing_strap_i,
    input  wire logic        sdio_timing_strap_i,
    output logic [4:0]       strap_pull_en_o,
    output logic [4:0]       strap_pull_up_o,
    output logic             strap_mode_o,
    // decoded settings
    output logic             volt_1v8_o,
    output logic [1:0]       sdio_timing_o,
    output logic [1:0]       boot_mode_o,
    output logic             boot_log_en_o,
    // boot log serial line
    input  wire logic        boot_log_tx_i,
    output logic             boot_log_tx_o
);

    // ==========================================
    // state
    // ==========================================
    typedef struct packed {
        logic [4:0]  strap;
        logic [4:0]  ovr;
        logic        in_boot;
        logic [15:0] boot_cnt;
        logic        ack;
        logic [31:0] rdata;
        logic        log_en;
        logic [1:0]  boot;
        bsl_cfg_t    cfg;
    } bsl_state_t;

    bsl_state_t st_q;
    bsl_state_t st_d;

    logic [4:0] pins;
    bsl_boot_t  boot_w;
    logic       log_w;
    bsl_cfg_t   cfg_w;

    // regulator strap is tied high inside the module
    assign pins = {sdio_timing_strap_i, log_and_timing_strap_i, boot_qualifier_strap_i,
                   boot_select_strap_i, 1'b1};

    bsl_decode u_dec (
        .strap_i  (st_q.strap),
        .ovr_i    (st_q.ovr),
        .boot_o   (boot_w),
        .log_en_o (log_w),
        .cfg_o    (cfg_w)
    );

    function automatic logic [31:0] bsl_wmask(input logic [3:0] sel);
        bsl_wmask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction : bsl_wmask

    // ==========================================
    // next state
    // ==========================================
    always_comb
    begin
        logic [31:0] m;
        m = bsl_wmask(wb_sel_i);
        st_d = st_q;
        st_d.ack = 1'b0;
        st_d.log_en = log_w;
        st_d.boot = boot_w;
        st_d.cfg = cfg_w;
        if (st_q.in_boot)
        begin
            if (st_q.boot_cnt == 16'(BOOT_CYCLES - 1))
            begin
                st_d.in_boot = 1'b0;
            end
            else
            begin
                st_d.boot_cnt = st_q.boot_cnt + 16'h0001;
            end
        end
        if (wb_cyc_i && wb_stb_i && !st_q.ack)
        begin
            st_d.ack = 1'b1;
            st_d.rdata = 32'h00000000;
            case (wb_adr_i)
                BSL_ADDR_STRAP:
                begin
                    st_d.rdata[4:0] = st_q.strap;
                end
                BSL_ADDR_OVERRIDE:
                begin
                    st_d.rdata[4:0] = st_q.ovr;
                    if (wb_we_i)
                    begin
                        st_d.ovr = 5'((({27'h0, st_q.ovr} & ~m) | (wb_dat_i & m))
                                      & BSL_OVR_MASK);
                    end
                end
                BSL_ADDR_EFFECT:
                begin
                    st_d.rdata[2:0] = st_q.cfg;
                end
                BSL_ADDR_BOOT:
                begin
                    st_d.rdata[3:0] = {st_q.in_boot, st_q.log_en, st_q.boot};
                end
                default:
                begin
                    st_d.rdata = 32'h00000000;
                end
            endcase
        end
    end

    // ==========================================
    // registers
    // ==========================================
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_q <= st_d;
            st_q.strap <= pins;
            st_q.ovr <= 5'h00;
            st_q.in_boot <= 1'b1;
            st_q.boot_cnt <= 16'h0000;
            st_q.ack <= 1'b0;
            st_q.rdata <= 32'h00000000;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ==========================================
    // outputs
    // ==========================================
    assign wb_ack_o = st_q.ack;
    assign wb_dat_o = st_q.rdata;
    assign strap_mode_o = rst_i;
    assign strap_pull_en_o = rst_i ? BSL_PULL_EN : 5'h00;
    assign strap_pull_up_o = BSL_PULL_UP;
    assign volt_1v8_o = st_q.cfg.volt_1v8;
    assign sdio_timing_o = st_q.cfg.sdio_timing;
    assign boot_mode_o = st_q.boot;
    assign boot_log_en_o = st_q.log_en;
    // silent line idles high; during boot the log passes only when enabled, after boot always
    assign boot_log_tx_o = (st_q.in_boot && !st_q.log_en) ? 1'b1 : boot_log_tx_i;

endmodule : bsl_top
